// [logic/drv_defs.svh]
// constants of the ten-channel serial-input latched driver
// assumes inclusion by bare name from the design files
`ifndef DRV_DEFS_SVH
`define DRV_DEFS_SVH

// number of shift stages, latches and driver outputs
`define DRV_CHANNELS 10

// snapshot buffer depth between shift clock and system clock
`define DRV_FIFO_DEPTH 8

// reset contents of shift register, mirror and latches
`define DRV_WORD_RST 10'h000

// driver output levels
`define DRV_BIT_ON 1'h1
`define DRV_BIT_OFF 1'h0

`endif

// [logic/drv_pkg.sv]
// types shared by the serial-input latched driver
// assumes drv_defs.svh is on the include path
package drv_pkg;

   // latch behaviour: holding, or transparent to the shift register
   typedef enum logic {
      LAT_HOLD,
      LAT_TRACK
   } latch_mode_t;

endpackage

// [logic/serial_latched_driver.sv]
// ten-channel serial-input latched driver with blanking
// assumes clk_shift comes from the controller and may stop between bursts;
// strobe and blank are asynchronous pins, other control inputs are on clk_sys
`timescale 1ns/1ps
`include "drv_defs.svh"
module serial_latched_driver #(
   parameter int WIDTH = `DRV_CHANNELS,
   parameter int DEPTH = `DRV_FIFO_DEPTH
) (
   // system clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // serial link from the controller
   input wire logic clk_shift,
   input wire logic serial_in,
   output logic serial_out,
   output logic shift_ready,
   // asynchronous control pins
   input wire logic strobe_in,
   input wire logic blank_in,
   // system-side controls
   input wire logic drain_hold,
   input wire logic stale_clr,
   // driver outputs and status
   output logic [WIDTH-1:0] drv_out,
   output logic track_active,
   output logic snap_stale
);

   // ************************************************************
   // state types
   // ************************************************************

   // shift clock domain
   typedef struct packed {
      logic [WIDTH-1:0] sreg;
      logic drop_tgl;
   } link_st_t;

   // system clock domain
   typedef struct packed {
      logic strobe_meta;
      logic strobe_sync;
      logic blank_meta;
      logic blank_sync;
      logic drop_meta;
      logic drop_sync;
      logic drop_seen;
      drv_pkg::latch_mode_t mode;
      logic [WIDTH-1:0] mirror;
      logic [WIDTH-1:0] latch;
      logic [WIDTH-1:0] drive;
      logic stale;
   } sys_st_t;

   link_st_t lq;
   link_st_t ld;
   sys_st_t sq;
   sys_st_t sd;

   // ************************************************************
   // snapshot carriers
   // ************************************************************

   stream_if #(.W(WIDTH)) push ();
   stream_if #(.W(WIDTH)) pop ();

   logic take;
   logic drop_evt;
   logic [WIDTH-1:0] mirror_now;
   logic [WIDTH-1:0] drive_next;

   // ************************************************************
   // shift register, shift clock domain
   // ************************************************************

   // every rising shift edge offers the new register contents
   assign push.valid = 1'h1;
   assign push.data = ld.sreg;
   assign shift_ready = push.ready;

   always_comb begin
      ld = lq;
      // serial input capture
      // serial level enters stage one on the rising edge
      ld.sreg[0] = serial_in;
      // stage-to-stage shift
      // stage n takes the old value of stage n-1
      ld.sreg[WIDTH-1:1] = lq.sreg[WIDTH-2:0];
      // a full buffer loses this snapshot; flag it across
      if (!push.ready) begin
         ld.drop_tgl = ~lq.drop_tgl;
      end
   end

   always_ff @(posedge clk_shift or negedge rstn) begin
      if (!rstn) begin
         lq <= '0;
      end else begin
         lq <= ld;
      end
   end

   // cascade output
   // taken straight from the last stage flop
   assign serial_out = lq.sreg[WIDTH-1];

   // ************************************************************
   // clock crossing buffer
   // ************************************************************

   // ten-wide data path
   // one word per snapshot, one bit per stage
   snap_fifo #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH)
   ) u_snap_fifo (
      .wr_clk(clk_shift),
      .rd_clk(clk_sys),
      .rstn(rstn),
      .push(push),
      .pop(pop)
   );

   // draining stalls while the system side asks to hold
   assign pop.ready = ~drain_hold;
   assign take = pop.valid & pop.ready;

   // ************************************************************
   // register mirror and latches, system clock domain
   // ************************************************************

   // newest known shift register contents
   assign mirror_now = take ? pop.data : sq.mirror;

   // drop toggle edge after its synchroniser
   assign drop_evt = sq.drop_sync ^ sq.drop_seen;

   always_comb begin
      sd = sq;

      // pin and drop-toggle synchronisers
      sd.strobe_meta = strobe_in;
      sd.strobe_sync = sq.strobe_meta;
      sd.blank_meta = blank_in;
      sd.blank_sync = sq.blank_meta;
      sd.drop_meta = lq.drop_tgl;
      sd.drop_sync = sq.drop_meta;
      sd.drop_seen = sq.drop_sync;

      sd.mirror = mirror_now;

      unique case (sq.mode)
         drv_pkg::LAT_HOLD: begin
            // latches hold
            // strobe low leaves the latches as they are
            if (sq.strobe_sync) begin
               // strobe copies register
               // rising strobe loads the current contents
               sd.mode = drv_pkg::LAT_TRACK;
               sd.latch = mirror_now;
            end
         end
         drv_pkg::LAT_TRACK: begin
            if (sq.strobe_sync) begin
               // transparent tracking
               // every new snapshot passes through while strobe stays high
               sd.latch = mirror_now;
            end else begin
               sd.mode = drv_pkg::LAT_HOLD;
            end
         end
      endcase

      // output stage
      sd.drive = drive_next;

      // lost-snapshot flag; a new loss beats a clear
      if (stale_clr) begin
         sd.stale = 1'h0;
      end
      if (drop_evt) begin
         sd.stale = 1'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sq <= '0;
      end else begin
         sq <= sd;
      end
   end

   // ************************************************************
   // output drivers, one per channel
   // ************************************************************

   for (genvar i = 0; i < WIDTH; i++) begin : g_drv
      always_comb begin
         if (sq.blank_sync) begin
            // blanking forces off
            // latch and shift contents are untouched here
            drive_next[i] = `DRV_BIT_OFF;
         end else if (sq.latch[i]) begin
            drive_next[i] = `DRV_BIT_ON;
         end else begin
            drive_next[i] = `DRV_BIT_OFF;
         end
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************

   assign drv_out = sq.drive;
   assign track_active = sq.mode == drv_pkg::LAT_TRACK;
   assign snap_stale = sq.stale;

endmodule

// [logic/snap_fifo.sv]
// dual-clock snapshot fifo with gray-coded pointers
// assumes push side on wr_clk, pop side on rd_clk, depth a power of two
`timescale 1ns/1ps
`include "drv_defs.svh"
module snap_fifo #(
   parameter int WIDTH = `DRV_CHANNELS,
   parameter int DEPTH = `DRV_FIFO_DEPTH
) (
   // clocks and reset
   input wire logic wr_clk,
   input wire logic rd_clk,
   input wire logic rstn,
   // filling side, wr_clk domain
   stream_if.snk push,
   // draining side, rd_clk domain
   stream_if.src pop
);
   localparam int AW = $clog2(DEPTH);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wbin;
      logic [AW:0] wgray;
      logic [AW:0] rg_meta;
      logic [AW:0] rg_sync;
   } wr_st_t;

   typedef struct packed {
      logic [AW:0] rbin;
      logic [AW:0] rgray;
      logic [AW:0] wg_meta;
      logic [AW:0] wg_sync;
   } rd_st_t;

   wr_st_t wq;
   wr_st_t wd;
   rd_st_t rq;
   rd_st_t rd;
   logic full;
   logic empty;

   // ************************************************************
   // write side
   // ************************************************************
   assign full = wq.wgray == {~wq.rg_sync[AW:AW-1], wq.rg_sync[AW-2:0]};
   assign push.ready = ~full;

   always_comb begin
      wd = wq;
      wd.rg_meta = rq.rgray;
      wd.rg_sync = wq.rg_meta;
      if (push.valid && !full) begin
         wd.mem[wq.wbin[AW-1:0]] = push.data;
         wd.wbin = wq.wbin + (AW+1)'(1);
         wd.wgray = wd.wbin ^ (wd.wbin >> 1);
      end
   end

   always_ff @(posedge wr_clk or negedge rstn) begin
      if (!rstn) begin
         wq <= '0;
      end else begin
         wq <= wd;
      end
   end

   // ************************************************************
   // read side
   // ************************************************************
   assign empty = rq.rgray == rq.wg_sync;
   assign pop.valid = ~empty;
   assign pop.data = wq.mem[rq.rbin[AW-1:0]];

   always_comb begin
      rd = rq;
      rd.wg_meta = wq.wgray;
      rd.wg_sync = rq.wg_meta;
      if (pop.ready && !empty) begin
         rd.rbin = rq.rbin + (AW+1)'(1);
         rd.rgray = rd.rbin ^ (rd.rbin >> 1);
      end
   end

   always_ff @(posedge rd_clk or negedge rstn) begin
      if (!rstn) begin
         rq <= '0;
      end else begin
         rq <= rd;
      end
   end
endmodule

// [logic/stream_if.sv]
// valid/ready word carrier between the driver's own modules
// assumes both ends share the clock of the side that owns the modport pair
`timescale 1ns/1ps
interface stream_if #(
   parameter int W = 10
) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;

   modport src (
      output valid,
      output data,
      input ready
   );

   modport snk (
      input valid,
      input data,
      output ready
   );
endinterface

// [test/drv_checker_properties.sv]
// port checker for the serial latched driver
// assumes a bind onto serial_latched_driver
`timescale 1ns/1ps
module drv_checker #(
   parameter int WIDTH = 10
) (
   // watched ports
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clk_shift,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic strobe_in,
   input wire logic blank_in,
   input wire logic drain_hold,
   input wire logic stale_clr,
   input wire logic [WIDTH-1:0] drv_out,
   input wire logic track_active,
   input wire logic snap_stale
);
   logic [3:0] edges_q;
   // shift edges since reset, stops at ten
   always_ff @(posedge clk_shift or negedge rstn) begin
      if (!rstn) edges_q <= 4'h0;
      else if (edges_q != 4'hA) edges_q <= edges_q + 4'h1;
   end
   a_blank_off: assert property (@(posedge clk_sys) disable iff (!rstn)
      blank_in [*4] |-> drv_out == '0) else $error("output on while blanked");
   a_blank_keep: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!strobe_in && !blank_in) [*5] ##1 (!strobe_in && blank_in) [*6]
      ##1 (!strobe_in && !blank_in) [*6] |-> drv_out == $past(drv_out, 12))
      else $error("outputs not restored");
   a_hold_stable: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!strobe_in && !blank_in) [*5] |=> $stable(drv_out)) else $error("outputs moved");
   a_track_on: assert property (@(posedge clk_sys) disable iff (!rstn)
      strobe_in [*4] |-> track_active) else $error("not tracking");
   a_track_off: assert property (@(posedge clk_sys) disable iff (!rstn)
      !strobe_in [*4] |-> !track_active) else $error("still tracking");
   a_cascade_out: assert property (@(posedge clk_shift) disable iff (!rstn)
      edges_q == 4'hA |-> serial_out == $past(serial_in, 10)) else $error("cascade bit");
   a_out_follows: assert property (@(posedge clk_sys) disable iff (!rstn)
      (strobe_in && !blank_in && !drain_hold && !clk_shift && !snap_stale) [*8]
      |-> drv_out[WIDTH-1] == serial_out) else $error("top output differs");
   a_stale_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
      (snap_stale && !stale_clr) [*2] |=> snap_stale) else $error("stale flag lost");
endmodule

bind serial_latched_driver drv_checker #(.WIDTH(WIDTH)) u_drv_checker (.clk_sys(clk_sys),
   .rstn(rstn), .clk_shift(clk_shift), .serial_in(serial_in), .serial_out(serial_out),
   .strobe_in(strobe_in), .blank_in(blank_in), .drain_hold(drain_hold),
   .stale_clr(stale_clr), .drv_out(drv_out), .track_active(track_active),
   .snap_stale(snap_stale));

// [test/serial_latched_driver_tb.sv]
// bench for the serial latched driver
// assumes the checker is bound and shift_ctrl drives the link
`timescale 1ns/1ps
module serial_latched_driver_tb;
   logic clk_sys, rstn, clk_shift, serial_in, serial_out, shift_ready;
   logic strobe_in, blank_in, drain_hold, stale_clr, track_active, snap_stale;
   logic [9:0] drv_out;
   int num_errors = 0;
   int check_count = 0;
   int model_reg = 0;
   int model_lat = 0;
   serial_latched_driver u_serial_latched_driver (.clk_sys(clk_sys), .rstn(rstn),
      .clk_shift(clk_shift), .serial_in(serial_in), .serial_out(serial_out),
      .shift_ready(shift_ready), .strobe_in(strobe_in), .blank_in(blank_in),
      .drain_hold(drain_hold), .stale_clr(stale_clr), .drv_out(drv_out),
      .track_active(track_active), .snap_stale(snap_stale));
   shift_ctrl u_shift_ctrl (.clk_shift(clk_shift), .serial_in(serial_in));
   initial begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [9:0] got, input int exp);
      check_count++;
      if (got !== exp[9:0]) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp[9:0]);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic push(input int word, input int slow);
      u_shift_ctrl.send(word[9:0], slow);
      model_reg = word & 32'h3FF;
      @(negedge clk_sys);
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // a run needs under 16 us; over twelve times that means a hang
   initial begin
      #200000;
      num_errors++;
      summarize();
   end
   initial begin
      rstn = 1'h0;
      strobe_in = 1'h0;
      blank_in = 1'h0;
      drain_hold = 1'h0;
      stale_clr = 1'h0;
      void'($urandom(32'hE8F722F2));
      tick(2);
      rstn = 1'h1;
      tick(1);
      check(drv_out, 0);
      check({track_active, snap_stale, shift_ready}, 1);
      for (int i = 0; i < 4; i++) begin
         push($urandom, i);
         check(10'(serial_out), model_reg >> 9);
         tick(10);
         check(drv_out, model_lat);
         strobe_in = 1'h1;
         tick(10);
         model_lat = model_reg;
         check(drv_out, model_lat);
         check(10'(track_active), 1);
         strobe_in = 1'h0;
         tick(6);
      end
      strobe_in = 1'h1;
      push($urandom, 0);
      tick(10);
      model_lat = model_reg;
      check(drv_out, model_lat);
      strobe_in = 1'h0;
      tick(8);
      blank_in = 1'h1;
      tick(5);
      check(drv_out, 0);
      tick(1);
      blank_in = 1'h0;
      tick(8);
      check(drv_out, model_lat);
      blank_in = 1'h1;
      push($urandom, 0);
      tick(4);
      check(drv_out, 0);
      blank_in = 1'h0;
      tick(8);
      check(drv_out, model_lat);
      strobe_in = 1'h1;
      tick(10);
      check(drv_out, model_reg);
      // blank while shifting with strobe held
      blank_in = 1'h1;
      push($urandom, 1);
      tick(8);
      check(drv_out, 0);
      blank_in = 1'h0;
      tick(8);
      model_lat = model_reg;
      check(drv_out, model_lat);
      strobe_in = 1'h0;
      tick(6);
      drain_hold = 1'h1;
      push($urandom, 0);
      check(10'(shift_ready), 0);
      tick(8);
      check(10'(snap_stale), 1);
      drain_hold = 1'h0;
      tick(20);
      // full flag only sees the drained reads on later shift edges
      push($urandom, 0);
      check(10'(shift_ready), 1);
      stale_clr = 1'h1;
      tick(1);
      stale_clr = 1'h0;
      tick(3);
      check(10'(snap_stale), 0);
      check(drv_out, model_lat);
      summarize();
   end
endmodule

// [test/shift_ctrl.sv]
// controller model: shift clock and serial data
// assumes send is called between frames; clock idles low
`timescale 1ns/1ps
module shift_ctrl (
   // link to the driver
   output logic clk_shift,
   output logic serial_in
);
   initial begin
      clk_shift = 1'h0;
      serial_in = 1'h0;
   end
   // first bit lands in the top stage; slow stretches low phases
   task automatic send(input logic [9:0] word, input int slow);
      for (int i = 9; i >= 0; i--) begin
         serial_in = word[i];
         repeat (slow + 1) #40;
         clk_shift = 1'h1;
         #40;
         clk_shift = 1'h0;
      end
      // released line shows the inverse of the last bit
      serial_in = ~word[0];
   endtask
endmodule
